/* File: rtl/scap_top.sv */
// Purpose: scan chain access port, byte FIFOs, JTAG engine, port mux
// Assumes: requesters share sys_clk_i; port pins are asynchronous
// Notes: engine timing follows the returned clock when enabled
//
// Function
// - up to eight scan chains, driven together by one engine, TDO from lowest enabled
// - legacy build refuses non-debugger agents
// - engine takes command bytes in order
// - engine samples TDO, pushes response bytes
// - mux routes eight ports, per-port control/status
// - returned clock supported; pins treated asynchronous
// - response FIFO holds exactly seven bytes
// - command FIFO holds four bytes
// - each port: clock, mode, data, test reset
// - missing returned clock is synthesised from TCK
// - each port: active-low subsystem reset output
// - responses readable while TDI still arrives
// - one to four bytes per write
// - response read stalls until bytes present
// - command write stalls until space free
// - status and control never stall

`timescale 1ns/1ps

module scap_top
	import scap_pkg::*;
(
	input wire logic sys_clk_i, // system clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic agent_is_debugger_i, // access comes from debug port
	input wire logic cmd_req_i, // command write request, level
	input wire scap_word_s cmd_word_i, // bytes and count to push
	output logic cmd_ack_o, // command write done, pulse
	input wire logic rsp_req_i, // response read request, level
	input wire logic [2:0] rsp_nbytes_i, // bytes to pop, 1..4
	output logic rsp_ack_o, // response read done, pulse
	output logic [31:0] rsp_data_o, // popped bytes, first in low byte
	output logic access_denied_o, // request refused, pulse
	input wire logic [NUM_PORTS-1:0] port_select_i, // chosen ports
	input wire logic trst_assert_i, // drive test reset low
	input wire logic srst_assert_i, // drive subsystem reset low
	input wire logic returned_test_clock_mode_i, // pace TCK by returned clock
	input wire logic [NUM_PORTS-1:0] port_present_i, // tie-off
	input wire logic [NUM_PORTS-1:0] subsystem_reset_present_i, // tie-off
	input wire scap_port_in_s port_in_i, // per-port pins in
	output scap_port_out_s port_out_o, // per-port pins out
	output logic [CMD_CNT_W-1:0] cmd_level_o, // bytes waiting
	output logic [RSP_CNT_W-1:0] rsp_level_o, // bytes readable
	output logic [NUM_PORTS-1:0] port_status_o, // present and active
	output logic engine_busy_o // engine running a command
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	scap_port_in_s pin;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= port_in_i;
			sync2 <= sync1;
		end
	end
	assign pin = sync2;

	// ----------------------------------------------------------------
	// port selection
	// ----------------------------------------------------------------
	function automatic logic [2:0] first_idx(input logic [NUM_PORTS-1:0] m);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = NUM_PORTS - 1; i >= 0; i--) begin
			if (m[i]) idx = 3'(i);
		end
		return idx;
	endfunction : first_idx

	logic tck_q;
	// a port takes part only when chosen, present and powered
	wire [NUM_PORTS-1:0] en_mask = port_select_i & port_present_i & pin.active;
	wire [2:0] sel_idx = first_idx(en_mask);
	wire sel_tdo = pin.tdo[sel_idx];
	wire sel_returned_test_clock = pin.returned_test_clock[sel_idx];
	// without a returned clock the engine loops its own TCK back
	wire ret_clk = returned_test_clock_mode_i ? sel_returned_test_clock : tck_q;
	wire acc_ok = ARCH_EXTENDED | agent_is_debugger_i;

	// ----------------------------------------------------------------
	// FIFOs
	// ----------------------------------------------------------------
	wire [CMD_CNT_W-1:0] cmd_count;
	wire [RSP_CNT_W-1:0] rsp_count;
	wire cmd_in_ready;
	wire cmd_out_valid;
	wire [7:0] b;
	wire rsp_in_ready;
	wire rsp_out_valid;
	wire [7:0] rsp_byte;
	wire cmd_push;
	wire cmd_pop;
	wire rsp_push;
	wire rsp_pop;
	scap_word_s wr_hold;
	logic [7:0] tdo_acc;

	scap_fifo #(.WIDTH(8), .DEPTH(CMD_DEPTH)) u_cmd_fifo (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(cmd_push),
		.in_ready_o(cmd_in_ready),
		.in_data_i(wr_hold.data[7:0]),
		.out_valid_o(cmd_out_valid),
		.out_ready_i(cmd_pop),
		.out_data_o(b),
		.count_o(cmd_count)
	);

	scap_fifo #(.WIDTH(8), .DEPTH(RSP_DEPTH)) u_rsp_fifo (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(rsp_push),
		.in_ready_o(rsp_in_ready),
		.in_data_i(tdo_acc),
		.out_valid_o(rsp_out_valid),
		.out_ready_i(rsp_pop),
		.out_data_o(rsp_byte),
		.count_o(rsp_count)
	);

	// ----------------------------------------------------------------
	// command write side
	// ----------------------------------------------------------------
	logic [2:0] wr_left;
	logic cmd_ack_q;
	logic denied_q;
	wire [CMD_CNT_W-1:0] cmd_free = CMD_CNT_W'(CMD_DEPTH) - cmd_count;
	// the whole word waits until every byte fits, so no partial write
	wire wr_accept = cmd_req_i && acc_ok && (wr_left == 3'h0) && !cmd_ack_q
		&& (cmd_free >= cmd_word_i.nbytes);
	assign cmd_push = (wr_left != 3'h0);

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_hold <= '0;
			wr_left <= 3'h0;
		end else if (wr_accept) begin
			wr_hold <= cmd_word_i;
			wr_left <= cmd_word_i.nbytes;
		end else if (cmd_push && cmd_in_ready) begin
			wr_hold.data <= {8'h00, wr_hold.data[31:8]};
			wr_left <= wr_left - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// response read side
	// ----------------------------------------------------------------
	logic [2:0] rd_left;
	logic [1:0] rd_idx;
	logic [31:0] rd_buf;
	logic rsp_ack_q;
	logic [31:0] rsp_data_q;
	wire rd_start = rsp_req_i && acc_ok && (rd_left == 3'h0) && !rsp_ack_q
		&& (rsp_nbytes_i != 3'h0) && (rsp_count >= rsp_nbytes_i);
	assign rsp_pop = (rd_left != 3'h0) && rsp_out_valid;
	wire [31:0] next_rd_buf = rd_buf | (32'(rsp_byte) << {rd_idx, 3'b000});

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_left <= 3'h0;
			rd_idx <= 2'h0;
			rd_buf <= 32'h0;
		end else if (rd_start) begin
			rd_left <= rsp_nbytes_i;
			rd_idx <= 2'h0;
			rd_buf <= 32'h0;
		end else if (rsp_pop) begin
			rd_left <= rd_left - 3'h1;
			rd_idx <= rd_idx + 2'h1;
			rd_buf <= next_rd_buf;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd_ack_q <= 1'b0;
			rsp_ack_q <= 1'b0;
			rsp_data_q <= 32'h0;
			denied_q <= 1'b0;
		end else begin
			cmd_ack_q <= wr_accept;
			rsp_ack_q <= rsp_pop && (rd_left == 3'h1);
			if (rsp_pop && (rd_left == 3'h1)) rsp_data_q <= next_rd_buf;
			denied_q <= (cmd_req_i || rsp_req_i) && !acc_ok && !denied_q;
		end
	end

	// ----------------------------------------------------------------
	// JTAG engine
	// ----------------------------------------------------------------
	scap_eng_e st;
	scap_eng_e next_st;
	logic [7:0] wait_cnt;
	logic [7:0] shreg;
	logic [3:0] nbits;
	logic [8:0] bytes_left;
	logic tms_mode;
	logic tdi_hold;
	logic cap;
	logic last_tms;
	logic tms_q;
	logic tdi_q;

	// the marker bit position gives the number of TMS bits below it
	wire [2:0] tms_n = b[5] ? 3'h5 : b[4] ? 3'h4 : b[3] ? 3'h3 : b[2] ? 3'h2 : b[1] ? 3'h1 : 3'h0;
	wire is_tms = !b[OP_MSB];
	wire is_scan = (b[7:5] == OP_SCAN);
	wire half_done = (wait_cnt >= HALF_LAST) && (ret_clk == tck_q);
	wire last_bit = (nbits == 4'h1);
	wire scan_end = (bytes_left == 9'h0);
	assign cmd_pop = cmd_out_valid && ((st == S_IDLE) || (st == S_LEN) || (st == S_DATA));
	assign rsp_push = (st == S_PUSH);

	always_comb begin
		next_st = st;
		unique case (st)
			S_IDLE: begin
				// reserved opcodes are popped and dropped
				if (cmd_out_valid && is_tms && (tms_n != 3'h0)) next_st = S_LOW;
				else if (cmd_out_valid && is_scan) next_st = S_LEN;
			end
			S_LEN: if (cmd_out_valid) next_st = S_DATA;
			S_DATA: if (cmd_out_valid) next_st = S_LOW;
			S_LOW: if (half_done) next_st = S_HIGH;
			S_HIGH: begin
				if (half_done) begin
					if (!last_bit) next_st = S_LOW;
					else if (tms_mode) next_st = S_IDLE;
					else if (cap) next_st = S_PUSH;
					else next_st = scan_end ? S_IDLE : S_DATA;
				end
			end
			S_PUSH: if (rsp_in_ready) next_st = scan_end ? S_IDLE : S_DATA;
			default: next_st = S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= S_IDLE;
			wait_cnt <= 8'h00;
			tck_q <= 1'b0;
		end else begin
			st <= next_st;
			// saturate so a stalled returned clock cannot wrap the count
			if (next_st != st) wait_cnt <= 8'h00;
			else if (wait_cnt != 8'hFF) wait_cnt <= wait_cnt + 8'h01;
			tck_q <= (next_st == S_HIGH);
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shreg <= 8'h00;
			nbits <= 4'h0;
			bytes_left <= 9'h000;
			tms_mode <= 1'b0;
			tdi_hold <= 1'b0;
			cap <= 1'b0;
			last_tms <= 1'b0;
		end else if (cmd_pop && (st == S_IDLE)) begin
			shreg <= b;
			nbits <= {1'b0, tms_n};
			tms_mode <= is_tms;
			tdi_hold <= b[TMS_TDI_BIT];
			cap <= b[HDR_CAP_BIT];
			last_tms <= b[HDR_LAST_TMS_BIT];
		end else if (cmd_pop && (st == S_LEN)) begin
			bytes_left <= {1'b0, b} + 9'h001;
		end else if (cmd_pop && (st == S_DATA)) begin
			shreg <= b;
			nbits <= BITS_PER_BYTE;
			bytes_left <= bytes_left - 9'h001;
		end else if ((st == S_HIGH) && half_done) begin
			shreg <= {1'b0, shreg[7:1]};
			nbits <= nbits - 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tms_q <= 1'b0;
			tdi_q <= 1'b0;
			tdo_acc <= 8'h00;
		end else begin
			if (st == S_LOW) begin
				tms_q <= tms_mode ? shreg[0] : (last_tms && scan_end && last_bit);
				tdi_q <= tms_mode ? tdi_hold : shreg[0];
			end
			// sampled late in the high phase, after the target has driven TDO
			if ((st == S_HIGH) && half_done && !tms_mode) tdo_acc <= {sel_tdo, tdo_acc[7:1]};
		end
	end

	// ----------------------------------------------------------------
	// port pins and status
	// ----------------------------------------------------------------
	scap_port_out_s out_q;
	wire [NUM_PORTS-1:0] chosen = port_select_i & port_present_i;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_q.tck <= PINS_LOW_RST;
			out_q.tms <= PINS_LOW_RST;
			out_q.tdi <= PINS_LOW_RST;
			out_q.trst_n <= PINS_HIGH_RST;
			out_q.srst_n <= PINS_HIGH_RST;
		end else begin
			out_q.tck <= en_mask & {NUM_PORTS{tck_q}};
			out_q.tms <= en_mask & {NUM_PORTS{tms_q}};
			out_q.tdi <= en_mask & {NUM_PORTS{tdi_q}};
			out_q.trst_n <= ~(chosen & {NUM_PORTS{trst_assert_i}});
			out_q.srst_n <= ~(chosen & subsystem_reset_present_i & {NUM_PORTS{srst_assert_i}});
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd_level_o <= '0;
			rsp_level_o <= '0;
			port_status_o <= PINS_LOW_RST;
			engine_busy_o <= 1'b0;
		end else begin
			cmd_level_o <= cmd_count;
			rsp_level_o <= rsp_count;
			port_status_o <= port_present_i & pin.active;
			engine_busy_o <= (st != S_IDLE);
		end
	end

	assign port_out_o = out_q;
	assign cmd_ack_o = cmd_ack_q;
	assign rsp_ack_o = rsp_ack_q;
	assign rsp_data_o = rsp_data_q;
	assign access_denied_o = denied_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence tms_fetch_s;
		(st == S_IDLE) && cmd_out_valid && is_tms && (tms_n != 3'h0);
	endsequence
	sequence last_high_s;
		(st == S_HIGH) && half_done && last_bit && !tms_mode && cap;
	endsequence

	rsp_depth_a: assert property (rsp_count <= 3'(RSP_DEPTH)) else $error("response fifo over seven");
	cmd_depth_a: assert property (cmd_count <= 3'(CMD_DEPTH)) else $error("command fifo over four");
	wr_space_a: assert property (cmd_ack_o |-> $past(cmd_free) >= $past(cmd_word_i.nbytes))
		else $error("command write taken without space");
	rd_data_a: assert property (rd_start |=> (rd_left != 3'h0) ##0 rsp_out_valid)
		else $error("response read started without data");
	engine_fetch_a: assert property (tms_fetch_s |=> (st == S_LOW) ##1 !tck_q)
		else $error("tms command not started");
	capture_push_a: assert property (last_high_s |=> rsp_push) else $error("captured byte not pushed");
	idle_tck_a: assert property (##1 ((port_out_o.tck & ~$past(chosen)) == '0))
		else $error("tck on unselected port");
	half_period_a: assert property ($rose(tck_q) |-> $past(wait_cnt) >= HALF_LAST)
		else $error("tck low phase too short");
	denied_a: assert property ((cmd_req_i && !acc_ok && !denied_q) |=> access_denied_o ##1 !access_denied_o)
		else $error("refused access not flagged");
	srst_a: assert property (srst_assert_i && chosen[0] && subsystem_reset_present_i[0]
		|=> !port_out_o.srst_n[0]) else $error("subsystem reset not driven");

endmodule : scap_top

/* File: pkg/scap_pkg.sv */
// Purpose: shared constants and types of the scan chain access port
// Assumes: 200 MHz system clock, eight scan chain ports
// Notes: the engine command layout is this block's own

package scap_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 8;
	localparam int CMD_DEPTH = 4;
	localparam int RSP_DEPTH = 7;
	localparam int CMD_CNT_W = $clog2(CMD_DEPTH + 1);
	localparam int RSP_CNT_W = $clog2(RSP_DEPTH + 1);
	localparam int SYNC_W = 3 * NUM_PORTS;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 200;
	localparam int TCK_HALF_NS = 60;
	// least time, so round up to whole cycles
	localparam int TCK_HALF_CYC = (TCK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] HALF_LAST = 8'(TCK_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// architecture and command byte layout
	// ----------------------------------------------------------------
	localparam logic ARCH_EXTENDED = 1'b0;
	localparam logic [2:0] OP_SCAN = 3'h4;
	localparam int OP_MSB = 7;
	localparam int TMS_TDI_BIT = 6;
	localparam int HDR_CAP_BIT = 4;
	localparam int HDR_LAST_TMS_BIT = 3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [NUM_PORTS-1:0] PINS_LOW_RST = 8'h00;
	localparam logic [NUM_PORTS-1:0] PINS_HIGH_RST = 8'hFF;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] nbytes;
		logic [31:0] data;
	} scap_word_s;

	typedef struct packed {
		logic [NUM_PORTS-1:0] tdo;
		logic [NUM_PORTS-1:0] returned_test_clock;
		logic [NUM_PORTS-1:0] active;
	} scap_port_in_s;

	typedef struct packed {
		logic [NUM_PORTS-1:0] tck;
		logic [NUM_PORTS-1:0] tms;
		logic [NUM_PORTS-1:0] tdi;
		logic [NUM_PORTS-1:0] trst_n;
		logic [NUM_PORTS-1:0] srst_n;
	} scap_port_out_s;

	typedef enum logic [2:0] {
		S_IDLE,
		S_LEN,
		S_DATA,
		S_LOW,
		S_HIGH,
		S_PUSH
	} scap_eng_e;

endpackage : scap_pkg

/* File: rtl/scap_fifo.sv */
// Purpose: synchronous byte FIFO with valid/ready on both sides
// Assumes: one clock, depth need not be a power of two
// Notes: count_o gives the exact occupancy

`timescale 1ns/1ps

module scap_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk_i, // system clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic in_valid_i, // push request
	output logic in_ready_o, // space free
	input wire logic [WIDTH-1:0] in_data_i, // push data
	output logic out_valid_o, // data held
	input wire logic out_ready_i, // pop request
	output logic [WIDTH-1:0] out_data_o, // head data
	output logic [$clog2(DEPTH+1)-1:0] count_o // occupancy
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;

	function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : wrap_inc

	wire do_push = in_valid_i && in_ready_o;
	wire do_pop = out_valid_o && out_ready_i;

	assign in_ready_o = (count != CW'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign count_o = count;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) wr_ptr <= wrap_inc(wr_ptr);
			if (do_pop) rd_ptr <= wrap_inc(rd_ptr);
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end

	// storage needs no reset, the count guards every read
	always_ff @(posedge sys_clk_i) begin
		if (do_push) mem[wr_ptr] <= in_data_i;
	end

endmodule : scap_fifo

/* File: verification/scap_chain_model.sv */
// Purpose: far-side scan chains, one bypass bit per port
// Assumes: TDI taken on rising TCK, TDO moves on falling TCK
// Notes: an unpowered chain shows inverted levels, never stale ones

`timescale 1ns/1ps

module scap_chain_model
	import scap_pkg::*;
(
	input wire scap_port_out_s pins_i, // pins from the mux
	input wire logic [NUM_PORTS-1:0] powered_i, // chain has power
	input wire logic slow_i, // long returned clock delay
	output scap_port_in_s pins_o // pins to the mux
);
	// ----------------------------------------------------------------
	// per-port bypass and returned clock
	// ----------------------------------------------------------------
	wire [NUM_PORTS-1:0] tdo_v;
	wire [NUM_PORTS-1:0] returned_test_clock_v;
	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
		logic byp = 1'b0;
		logic tdo_r = 1'b0;
		wire fast_w;
		wire slow_w;
		always @(posedge pins_i.tck[i] or negedge pins_i.trst_n[i]) begin
			if (!pins_i.trst_n[i]) begin
				byp <= 1'b0;
			end else begin
				byp <= pins_i.tdi[i];
			end
		end
		always @(negedge pins_i.tck[i]) begin
			tdo_r <= byp;
		end
		assign #5 fast_w = pins_i.tck[i];
		// slower than a whole half period, so the mux must really wait
		assign #70 slow_w = pins_i.tck[i];
		assign tdo_v[i] = powered_i[i] ? tdo_r : ~tdo_r;
		assign returned_test_clock_v[i] = powered_i[i] ? (slow_i ? slow_w : fast_w) : ~pins_i.tck[i];
	end
	assign pins_o = {tdo_v, returned_test_clock_v, powered_i};
endmodule : scap_chain_model

/* File: verification/tb_scap_top.sv */
// Purpose: self-checking bench of the scan chain access port
// Assumes: partner chains echo TDI one bit late through a bypass bit
// Notes: inputs change 1 ns after a rising clock edge

`timescale 1ns/1ps

module tb_scap_top
	import scap_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic agent_is_debugger_i = 1'b1;
	logic cmd_req_i = 1'b0;
	scap_word_s cmd_word_i = '0;
	logic rsp_req_i = 1'b0;
	logic [2:0] rsp_nbytes_i = 3'h1;
	logic [NUM_PORTS-1:0] port_select_i = 8'h01;
	logic trst_assert_i = 1'b0;
	logic srst_assert_i = 1'b0;
	logic returned_test_clock_mode_i = 1'b0;
	logic [NUM_PORTS-1:0] port_present_i = 8'h0F;
	logic [NUM_PORTS-1:0] subsystem_reset_present_i = 8'h01;
	logic [NUM_PORTS-1:0] powered = 8'hFF;
	logic slow = 1'b0;
	scap_port_in_s port_in_i;
	scap_port_out_s port_out_o;
	logic cmd_ack_o, rsp_ack_o, access_denied_o, engine_busy_o;
	logic [31:0] rsp_data_o;
	logic [CMD_CNT_W-1:0] cmd_level_o;
	logic [RSP_CNT_W-1:0] rsp_level_o;
	logic [NUM_PORTS-1:0] port_status_o;
	int miscompares = 0;
	int comparisons = 0;
	int tck1_edges = 0;
	logic tms_q[$];
	logic tdi_q[$];
	logic last = 1'b0;
	logic ok;
	logic [31:0] got;
	logic [31:0] got2;
	realtime t_rise = 0.0;
	realtime hi_ns = 0.0;

	always #2.5 sys_clk_i = ~sys_clk_i;

	scap_top i_dut (
		.sys_clk_i, .arst_n_i, .agent_is_debugger_i, .cmd_req_i, .cmd_word_i, .cmd_ack_o,
		.rsp_req_i, .rsp_nbytes_i, .rsp_ack_o, .rsp_data_o, .access_denied_o, .port_select_i,
		.trst_assert_i, .srst_assert_i, .returned_test_clock_mode_i, .port_present_i, .subsystem_reset_present_i,
		.port_in_i, .port_out_o, .cmd_level_o, .rsp_level_o, .port_status_o, .engine_busy_o
	);

	scap_chain_model i_chain (.pins_i(port_out_o), .powered_i(powered), .slow_i(slow), .pins_o(port_in_i));

	always @(posedge port_out_o.tck[0]) begin
		t_rise = $realtime;
		tms_q.push_back(port_out_o.tms[0]);
		tdi_q.push_back(port_out_o.tdi[0]);
	end
	always @(negedge port_out_o.tck[0]) begin
		hi_ns = $realtime - t_rise;
	end
	always @(posedge port_out_o.tck[1]) begin
		tck1_edges++;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] a, input logic [31:0] e);
		comparisons++;
		if (a !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, a, e);
		end
	endtask : check

	task automatic timed_out();
		miscompares++;
		$display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
		wrap_up();
	endtask : timed_out

	task automatic step(input int n);
		repeat (n) begin
			@(posedge sys_clk_i);
			#1;
		end
	endtask : step

	// an edge passes before each request, so req is never dropped and raised at once
	task automatic cmd_write(input logic [2:0] n, input logic [31:0] d, output logic k);
		int i;
		step(1);
		cmd_word_i = '{nbytes: n, data: d};
		cmd_req_i = 1'b1;
		for (i = 0; i < 20000; i++) begin
			step(1);
			if (cmd_ack_o === 1'b1 || access_denied_o === 1'b1) break;
		end
		if (i == 20000) timed_out();
		k = cmd_ack_o;
		cmd_req_i = 1'b0;
	endtask : cmd_write

	task automatic rsp_read(input logic [2:0] n, output logic [31:0] d);
		int i;
		step(1);
		rsp_nbytes_i = n;
		rsp_req_i = 1'b1;
		for (i = 0; i < 20000; i++) begin
			step(1);
			if (rsp_ack_o === 1'b1 || access_denied_o === 1'b1) break;
		end
		if (i == 20000) timed_out();
		ok = rsp_ack_o;
		d = rsp_data_o;
		rsp_req_i = 1'b0;
	endtask : rsp_read

	task automatic wait_idle();
		int i;
		step(4);
		for (i = 0; i < 20000; i++) begin
			if (engine_busy_o === 1'b0 && cmd_level_o === '0) break;
			step(1);
		end
		if (i == 20000) timed_out();
	endtask : wait_idle

	// bypass chain: each captured bit is the TDI bit sent one clock earlier
	function automatic logic [63:0] scan_exp(input logic [63:0] d, input int n, input logic p);
		logic [63:0] r;
		r = '0;
		for (int j = 0; j < n; j++) begin
			r[8*j+:8] = {d[8*j+:7], p};
			p = d[8*j+7];
		end
		return r;
	endfunction : scan_exp

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin : main
		logic [7:0] b;
		logic [4:0] pat;
		logic [63:0] dd;
		logic [63:0] ex;
		int i;
		repeat (5) @(posedge sys_clk_i);
		check({8'h00, port_out_o.tck, port_out_o.trst_n, port_out_o.srst_n}, 32'h0000FFFF);
		check({rsp_level_o, cmd_level_o, engine_busy_o}, 32'h0);
		#1 arst_n_i = 1'b1;
		step(5);
		check(port_status_o, 8'h0F);
		port_select_i = 8'h03;
		trst_assert_i = 1'b1;
		srst_assert_i = 1'b1;
		step(3);
		check({port_out_o.trst_n, port_out_o.srst_n}, 16'hFCFE);
		trst_assert_i = 1'b0;
		srst_assert_i = 1'b0;
		step(3);
		check({port_out_o.trst_n, port_out_o.srst_n}, 16'hFFFF);
		port_select_i = 8'h01;
		$display("reset pin test done");
		pat = 5'b10110;
		for (int k = 1; k <= 5; k++) begin
			tms_q.delete();
			tdi_q.delete();
			b = 8'h01 << k;
			b = b | (8'(pat) & (b - 8'h01)) | {1'b0, k[0], 6'h00};
			cmd_write(3'h1, {24'h0, b}, ok);
			wait_idle();
			check(tms_q.size(), k);
			for (int j = 0; j < k; j++) begin
				check({tms_q[j], tdi_q[j]}, {pat[j], b[6]});
			end
			last = b[6];
		end
		$display("mode packet test done");
		tms_q.delete();
		tdi_q.delete();
		dd = 64'h3CA5;
		ex = scan_exp(dd, 2, last);
		cmd_write(3'h2, 32'h0190, ok);
		fork
			rsp_read(3'h2, got);
			cmd_write(3'h2, dd[31:0], ok);
		join
		wait_idle();
		check(got, ex[31:0]);
		for (int j = 0; j < 16; j++) begin
			check({tms_q[j], tdi_q[j]}, {1'b0, dd[j]});
		end
		$display("short scan test done");
		dd = 64'hF00FC33CA55A9669;
		cmd_write(3'h4, {dd[15:0], 16'h0790}, ok);
		cmd_write(3'h4, dd[47:16], ok);
		cmd_write(3'h2, {16'h0, dd[63:48]}, ok);
		ex = scan_exp(dd, 8, 1'b0);
		for (i = 0; i < 20000; i++) begin
			step(1);
			if (rsp_level_o === 3'd7) break;
		end
		if (i == 20000) timed_out();
		step(40);
		check({engine_busy_o, rsp_level_o}, 32'hF);
		rsp_read(3'h4, got);
		rsp_read(3'h4, got2);
		check(got, ex[31:0]);
		check(got2, ex[63:32]);
		wait_idle();
		$display("long scan test done");
		agent_is_debugger_i = 1'b0;
		cmd_write(3'h1, 32'h43, ok);
		check(ok, 1'b0);
		rsp_read(3'h1, got);
		check(ok, 1'b0);
		agent_is_debugger_i = 1'b1;
		step(3);
		check(cmd_level_o, 32'h0);
		$display("refusal test done");
		// reserved opcode is dropped; scan without capture, TMS high on its last bit
		tms_q.delete();
		tdi_q.delete();
		b = 8'h5A;
		cmd_write(3'h4, {b, 24'h0088A0}, ok);
		wait_idle();
		check(tms_q.size(), 8);
		for (int j = 0; j < 8; j++) begin
			check({tms_q[j], tdi_q[j]}, {1'(j == 7), b[j]});
		end
		check(rsp_level_o, 3'h0);
		$display("scan option test done");
		port_select_i = 8'h03;
		powered = 8'hFD;
		step(5);
		check(port_status_o, 8'h0D);
		tms_q.delete();
		tck1_edges = 0;
		cmd_write(3'h1, 32'h03, ok);
		wait_idle();
		check(tck1_edges, 0);
		check(tms_q.size(), 1);
		powered = 8'hFF;
		port_select_i = 8'h01;
		$display("inactive port test done");
		returned_test_clock_mode_i = 1'b1;
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			tms_q.delete();
			cmd_write(3'h1, 32'h43, ok);
			wait_idle();
			check(tms_q.size(), 1);
			check(tms_q[0], 1'b1);
			// a late returned clock must stretch the high phase past its delay
			check(hi_ns > 70.0, s[0]);
		end
		returned_test_clock_mode_i = 1'b0;
		$display("returned clock test done");
		wrap_up();
	end
endmodule : tb_scap_top
